// [spmux_pkg.sv]
/*
  Package for the serial port two strap pin multiplexer: pin indices,
  function encodings and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spmux_pkg;
  localparam int unsigned PIN_A        = 0;
  localparam int unsigned PIN_B        = 1;
  localparam int unsigned PIN_C        = 2;
  localparam int unsigned PIN_D        = 3;
  localparam int unsigned NUM_PINS     = 4;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam logic        MODE_GPIO    = 1'b0;
  localparam logic        MODE_SERIAL  = 1'b1;
  localparam logic        RST_MODE     = 1'b0;
  localparam logic        RST_TX_LEVEL = 1'b1;
  localparam logic        OE_OFF       = 1'b1;
  localparam logic        OE_ON        = 1'b0;
  localparam logic [2:0]  RST_SYNC     = 3'h0;
endpackage

// [spmux_sync.sv]
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous input and one clock domain.
*/
`timescale 1ns/100ps
module spmux_sync
  import spmux_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } spmux_sync_state_t;

  spmux_sync_state_t state_r;
  spmux_sync_state_t state_nxt;

  always_comb begin
    state_nxt       = state_r;
    state_nxt.stage = {state_r.stage[1:0], async_i};
    // Count a change once stages two and three agree
    if (state_r.stage[1] == state_r.stage[2]) begin
      state_nxt.level = state_r.stage[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '{stage: RST_SYNC, level: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Agreed level leaves at once, register keeps it between agreements
  assign sync_o = state_nxt.level;
endmodule

// [spmux_top.sv]
/*
  Strap-selected pin multiplexer for the shared pins of serial port two.
  Assumes the strap line is steady through reset and that the serial
  port, UART and GPIO logic sit on the same clock as this block.
*/
`timescale 1ns/100ps
module spmux_top
  import spmux_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic strap_select_line_i,
  input  wire logic shared_pin_a_i,
  output logic      shared_pin_a_o,
  output logic      shared_pin_a_oe_n_o,
  input  wire logic shared_pin_b_i,
  output logic      shared_pin_b_o,
  output logic      shared_pin_b_oe_n_o,
  input  wire logic shared_pin_c_i,
  output logic      shared_pin_c_o,
  output logic      shared_pin_c_oe_n_o,
  input  wire logic shared_pin_d_i,
  output logic      shared_pin_d_o,
  output logic      shared_pin_d_oe_n_o,
  output logic      serial_mode_o,
  input  wire logic general_io_three_out_i,
  input  wire logic general_io_three_en_i,
  output logic      general_io_three_o,
  input  wire logic general_io_five_out_i,
  input  wire logic general_io_five_en_i,
  output logic      general_io_five_o,
  input  wire logic uart_tx_i,
  output logic      uart_rx_o,
  input  wire logic tx_bit_clock_out_i,
  input  wire logic tx_bit_clock_en_i,
  output logic      tx_bit_clock_o,
  input  wire logic rx_bit_clock_out_i,
  input  wire logic rx_bit_clock_en_i,
  output logic      rx_bit_clock_o,
  input  wire logic tx_frame_sync_out_i,
  input  wire logic tx_frame_sync_en_i,
  output logic      tx_frame_sync_o,
  input  wire logic rx_frame_sync_out_i,
  input  wire logic rx_frame_sync_en_i,
  output logic      rx_frame_sync_o
);
  typedef struct packed {
    logic       armed;
    logic       mode;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic       io_three;
    logic       io_five;
    logic [3:0] serial_in;
    logic       uart_rx;
  } spmux_state_t;

  spmux_state_t state_r;
  spmux_state_t state_nxt;
  logic         strap_s;
  logic [3:0]   pin_s;

  // Strap path unreset: it must track the strap while reset is low
  spmux_sync u_sync_strap (
    .clk_i   (clk_i),
    .rst_n_i (1'b1),
    .async_i (strap_select_line_i),
    .sync_o  (strap_s)
  );

  spmux_sync u_sync_a (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(shared_pin_a_i),
                       .sync_o(pin_s[PIN_A]));
  spmux_sync u_sync_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(shared_pin_b_i),
                       .sync_o(pin_s[PIN_B]));
  spmux_sync u_sync_c (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(shared_pin_c_i),
                       .sync_o(pin_s[PIN_C]));
  spmux_sync u_sync_d (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(shared_pin_d_i),
                       .sync_o(pin_s[PIN_D]));

  // Output enable from a function's drive request
  function automatic logic oe_of(input logic en);
    return en ? OE_ON : OE_OFF;
  endfunction

  always_comb begin
    state_nxt = state_r;
    // Strap caught on the first edge after release, then frozen
    if (!state_r.armed) begin
      state_nxt.armed = 1'b1;
      state_nxt.mode  = strap_s;
    end
    // Function inputs gated by the mode in force next cycle
    state_nxt.io_three  = pin_s[PIN_A] & ~state_nxt.mode;
    state_nxt.io_five   = pin_s[PIN_C] & ~state_nxt.mode;
    state_nxt.serial_in = pin_s & {4{state_nxt.mode}};
    state_nxt.uart_rx   = pin_s[PIN_D] | state_nxt.mode;
    if (state_nxt.mode == MODE_SERIAL) begin
      state_nxt.pin_out[PIN_A]  = tx_bit_clock_out_i;
      state_nxt.pin_oe_n[PIN_A] = oe_of(tx_bit_clock_en_i);
      state_nxt.pin_out[PIN_B]  = rx_bit_clock_out_i;
      state_nxt.pin_oe_n[PIN_B] = oe_of(rx_bit_clock_en_i);
      state_nxt.pin_out[PIN_C]  = tx_frame_sync_out_i;
      state_nxt.pin_oe_n[PIN_C] = oe_of(tx_frame_sync_en_i);
      state_nxt.pin_out[PIN_D]  = rx_frame_sync_out_i;
      state_nxt.pin_oe_n[PIN_D] = oe_of(rx_frame_sync_en_i);
    end else begin
      state_nxt.pin_out[PIN_A]  = general_io_three_out_i;
      state_nxt.pin_oe_n[PIN_A] = oe_of(general_io_three_en_i);
      state_nxt.pin_out[PIN_B]  = uart_tx_i;
      state_nxt.pin_oe_n[PIN_B] = OE_ON;
      state_nxt.pin_out[PIN_C]  = general_io_five_out_i;
      state_nxt.pin_oe_n[PIN_C] = oe_of(general_io_five_en_i);
      state_nxt.pin_out[PIN_D]  = 1'b0;
      state_nxt.pin_oe_n[PIN_D] = OE_OFF;
    end
  end

  // Reset state: GPIO mode, pin B driven high, others released
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '{armed: 1'b0, mode: RST_MODE, pin_out: 4'h2, pin_oe_n: 4'hd,
                   io_three: 1'b0, io_five: 1'b0, serial_in: 4'h0,
                   uart_rx: RST_TX_LEVEL};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Inputs to functions not selected are held at zero, except uart receive, which is held high
  assign shared_pin_a_o       = state_r.pin_out[PIN_A];
  assign shared_pin_a_oe_n_o  = state_r.pin_oe_n[PIN_A];
  assign shared_pin_b_o       = state_r.pin_out[PIN_B];
  assign shared_pin_b_oe_n_o  = state_r.pin_oe_n[PIN_B];
  assign shared_pin_c_o       = state_r.pin_out[PIN_C];
  assign shared_pin_c_oe_n_o  = state_r.pin_oe_n[PIN_C];
  assign shared_pin_d_o       = state_r.pin_out[PIN_D];
  assign shared_pin_d_oe_n_o  = state_r.pin_oe_n[PIN_D];
  assign serial_mode_o        = state_r.mode;
  assign general_io_three_o   = state_r.io_three;
  assign general_io_five_o    = state_r.io_five;
  assign uart_rx_o            = state_r.uart_rx;
  assign tx_bit_clock_o       = state_r.serial_in[PIN_A];
  assign rx_bit_clock_o       = state_r.serial_in[PIN_B];
  assign tx_frame_sync_o      = state_r.serial_in[PIN_C];
  assign rx_frame_sync_o      = state_r.serial_in[PIN_D];

  // Mode latch checks
  a_mode_frozen: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && $past(state_r.armed) |-> $stable(state_r.mode))
    else $error("mode changed after latch");
  a_mode_from_strap: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(state_r.armed) |-> state_r.mode == $past(strap_s))
    else $error("mode not taken from strap");

  // Uart side checks
  a_tx_idle_high: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !state_r.mode && !state_r.armed |-> shared_pin_b_o && !shared_pin_b_oe_n_o)
    else $error("uart transmit not high at start");
  a_tx_follows: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !state_nxt.mode |=> shared_pin_b_o == $past(uart_tx_i))
    else $error("pin B not following uart transmit");
  a_pin_b_drive: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !serial_mode_o |-> !shared_pin_b_oe_n_o)
    else $error("pin B released in uart mode");
  a_rx_input: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !state_r.mode |-> shared_pin_d_oe_n_o == OE_OFF)
    else $error("pin D driven in uart mode");
  a_uart_rx_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !state_nxt.mode |=> uart_rx_o == $past(pin_s[PIN_D]))
    else $error("uart receive not following pin D");
  a_uart_rx_held: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    serial_mode_o |-> uart_rx_o)
    else $error("uart receive not idle in serial mode");

  // General io checks
  a_io_five_in: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !state_r.mode && !$past(general_io_five_en_i) && state_r.armed
      |-> shared_pin_c_oe_n_o == OE_OFF)
    else $error("io five driven without enable");
  a_io_three_in: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !state_r.mode && !$past(general_io_three_en_i) && state_r.armed
      |-> shared_pin_a_oe_n_o == OE_OFF)
    else $error("io three driven without enable");
  a_io_five_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !state_nxt.mode |=> general_io_five_o == $past(pin_s[PIN_C]))
    else $error("io five not following pin C");
  a_io_three_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && !state_nxt.mode |=> general_io_three_o == $past(pin_s[PIN_A]))
    else $error("io three not following pin A");
  a_io_gated_off: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    serial_mode_o |-> !general_io_three_o && !general_io_five_o)
    else $error("io input seen in serial mode");

  // Serial port checks
  a_serial_gated_off: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !serial_mode_o |-> !tx_bit_clock_o && !rx_bit_clock_o
      && !tx_frame_sync_o && !rx_frame_sync_o)
    else $error("serial input seen in io mode");
  a_fsx_dir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode
      |=> shared_pin_c_oe_n_o == !$past(tx_frame_sync_en_i))
    else $error("tx frame sync direction wrong");
  a_fsr_dir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode
      |=> shared_pin_d_oe_n_o == !$past(rx_frame_sync_en_i))
    else $error("rx frame sync direction wrong");
  a_fsx_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode |=> tx_frame_sync_o == $past(pin_s[PIN_C]))
    else $error("tx frame sync not following pin C");
  a_fsr_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode |=> rx_frame_sync_o == $past(pin_s[PIN_D]))
    else $error("rx frame sync not following pin D");
  a_clkx_dir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode
      |=> shared_pin_a_oe_n_o == !$past(tx_bit_clock_en_i))
    else $error("tx bit clock direction wrong");
  a_clkr_dir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    state_r.armed && state_nxt.mode
      |=> shared_pin_b_oe_n_o == !$past(rx_bit_clock_en_i))
    else $error("rx bit clock direction wrong");
endmodule

// [spmux_board.sv]
/*
  Board-side model: external serial devices on the shared pins and the strap wiring.
  Assumes the bench supplies the far-side drive values and the wanted strap level.
*/
`timescale 1ns/100ps
module spmux_board (
  input  wire logic       rst_n_i,
  input  wire logic       strap_req_i,
  input  wire logic [3:0] dev_i,
  input  wire logic [3:0] dev_oe_n_i,
  input  wire logic [3:0] ext_i,
  output logic            strap_o,
  output logic [3:0]      lvl_o
);
  logic held = 1'b0;
  // Strap frozen through reset
  always @(negedge rst_n_i) held <= strap_req_i;
  assign strap_o = rst_n_i ? strap_req_i : held;
  // Far side drives only pins that the device releases
  assign lvl_o = (dev_oe_n_i & ext_i) | (~dev_oe_n_i & dev_i);
endmodule

// [tb.sv]
/*
  Self-checking bench for the strap pin multiplexer with a reference model.
  Assumes spmux_pkg, spmux_top and spmux_board are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import spmux_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        strap_req = 1'b0;
  logic        strap;
  logic [12:0] fin = 13'h0;
  logic [3:0]  ext = 4'h0;
  logic [3:0]  po, poe, lvl;
  logic [6:0]  fo;
  logic        mode;
  logic [31:0] s = 32'h63a20963;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  spmux_top spmux_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .strap_select_line_i(strap),
    .shared_pin_a_i(lvl[0]), .shared_pin_a_o(po[0]), .shared_pin_a_oe_n_o(poe[0]),
    .shared_pin_b_i(lvl[1]), .shared_pin_b_o(po[1]), .shared_pin_b_oe_n_o(poe[1]),
    .shared_pin_c_i(lvl[2]), .shared_pin_c_o(po[2]), .shared_pin_c_oe_n_o(poe[2]),
    .shared_pin_d_i(lvl[3]), .shared_pin_d_o(po[3]), .shared_pin_d_oe_n_o(poe[3]),
    .serial_mode_o(mode), .uart_tx_i(fin[12]), .uart_rx_o(fo[2]),
    .general_io_three_out_i(fin[0]), .general_io_three_en_i(fin[1]),
    .general_io_three_o(fo[0]), .general_io_five_out_i(fin[2]),
    .general_io_five_en_i(fin[3]), .general_io_five_o(fo[1]),
    .tx_bit_clock_out_i(fin[4]), .tx_bit_clock_en_i(fin[5]), .tx_bit_clock_o(fo[3]),
    .rx_bit_clock_out_i(fin[6]), .rx_bit_clock_en_i(fin[7]), .rx_bit_clock_o(fo[4]),
    .tx_frame_sync_out_i(fin[8]), .tx_frame_sync_en_i(fin[9]), .tx_frame_sync_o(fo[5]),
    .rx_frame_sync_out_i(fin[10]), .rx_frame_sync_en_i(fin[11]), .rx_frame_sync_o(fo[6]));
  spmux_board spmux_board_i (.rst_n_i(rst_n_i), .strap_req_i(strap_req), .dev_i(po),
    .dev_oe_n_i(poe), .ext_i(ext), .strap_o(strap), .lvl_o(lvl));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reference model of drive, enable and returned levels
  task automatic check_all(input logic m);
    logic [3:0] de, dv, lv;
    logic [6:0] ef;
    de = m ? {fin[11], fin[9], fin[7], fin[5]} : {1'b0, fin[3], 1'b1, fin[1]};
    dv = m ? {fin[10], fin[8], fin[6], fin[4]} : {1'b0, fin[2], fin[12], fin[0]};
    lv = (de & dv) | (~de & ext);
    ef = m ? {lv, 3'b100} : {4'h0, lv[3], lv[2], lv[0]};
    chk(7'(mode), 7'(m));
    for (int p = 0; p < 4; p++) begin
      chk(7'(poe[p]), 7'(!de[p]));
      if (de[p]) chk(7'(po[p]), 7'(dv[p]));
    end
    chk(fo, ef);
  endtask
  task automatic do_reset(input logic m);
    strap_req = m;
    fin = 13'h0;
    step(8);
    rst_n_i = 1'b0;
    step(3);
    chk(7'(poe[1]), 7'(OE_ON));
    chk(7'(po[1]), 7'(RST_TX_LEVEL));
    chk(7'(fo[2]), 7'h01);
    step(5);
    rst_n_i = 1'b1;
    step(8);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    step(3);
    rst_n_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      do_reset(i[0]);
      check_all(i[0]);
      strap_req = ~i[0];
      for (int k = 0; k < 25; k++) begin
        s = lfsr(s);
        fin = s[12:0];
        ext = s[19:16];
        step(6);
        check_all(i[0]);
      end
    end
    test_done;
  end
endmodule
